// ==== sync_serial_regs.svh ====
// Register offsets, field positions, reset values and counts
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

`define OFS_BAUD_CONTROL   8'h00
`define OFS_RX_STAT_CTRL   8'h04
`define OFS_BAUD_DIV_LOW   8'h08
`define OFS_BAUD_DIV_HIGH  8'h0C
`define OFS_TX_DATA        8'h10
`define OFS_TX_STAT_CTRL   8'h14
`define OFS_RX_DATA        8'h18

`define BAUD_RX_IDLE       6
`define BAUD_CLK_POLARITY  4
`define BAUD_WIDE_DIVISOR  3

`define RX_PORT_ENABLE     7
`define RX_NINE_BIT        6
`define RX_SINGLE          5
`define RX_CONTINUOUS      4
`define RX_OVERRUN         1
`define RX_NINTH_BIT       0

`define TX_MASTER_CLOCK    7
`define TX_NINE_BIT        6
`define TX_ENABLE          5
`define TX_SYNC_MODE       4
`define TX_HIGH_RATE       2
`define TX_SHIFT_EMPTY     1
`define TX_NINTH_BIT       0

`define REG_RESET          8'h00
`define FIFO_DEPTH         2'h2
`define BITS_SHORT         4'h8
`define BITS_LONG          4'h9

`endif

// ==== sync_serial_pkg.sv ====
// Types shared by the synchronous serial port
package sync_serial_pkg;

	typedef enum logic [1:0]
	{
		st_idle  = 2'b00,
		st_lead  = 2'b01,
		st_trail = 2'b11
	} clk_state_t;

	typedef logic [8:0] char_t;

endpackage : sync_serial_pkg

// ==== sync_serial_port.sv ====
// Half-duplex synchronous serial port, master or slave, Wishbone registers
`timescale 1ns/10ps
`include "sync_serial_regs.svh"

module sync_serial_port
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        data_i,
	output logic             data_o,
	output logic             data_oe_n_o,
	input  wire logic        strobe_i,
	output logic             strobe_o,
	output logic             strobe_oe_n_o,
	output logic             receive_flag_o
);
	import sync_serial_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic              clock_polarity_select;
	logic              wide_divisor_select;
	logic              serial_port_enable;
	logic              nine_bit_receive;
	logic              single_receive_enable;
	logic              continuous_receive_enable;
	logic              master_clock_source;
	logic              nine_bit_transmit;
	logic              transmit_enable_bit;
	logic              sync_mode;
	logic              high_rate_select;
	logic              transmit_ninth_bit;
	logic [7:0]        baud_divisor_low;
	logic [7:0]        baud_divisor_high;
	logic [7:0]        transmit_data_register;
	logic              tdr_full;
	logic              overrun_error_flag;
	logic              overrun_single;

	// Engine, FIFO and pin state
	clk_state_t        state;
	logic [15:0]       half_cnt;
	logic [3:0]        bit_cnt;
	char_t             transmit_shift_register;
	logic              tsr_busy;
	char_t             receive_shift_register;
	char_t             fifo [0:1];
	logic              rd_ptr;
	logic [1:0]        fifo_count;
	logic              data_s1;
	logic              data_s;
	logic              strobe_s1;
	logic              strobe_s;
	logic              strobe_d;

	// Combinational terms
	logic              access;
	logic              wr_en;
	logic              pop;
	logic              port_on;
	logic              receiving;
	logic              tx_run;
	logic              rx_run;
	logic              go;
	logic              half_tick;
	logic              lead_ev;
	logic              trail_ev;
	logic              last_bit;
	logic              rx_done;
	logic [3:0]        char_bits;
	logic [15:0]       divisor;
	char_t             next_rsr;
	char_t             rx_char;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	always_comb
	begin
		access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		wr_en  = access & wb_we_i & wb_sel_i[0];
		pop    = access & ~wb_we_i & (wb_adr_i == `OFS_RX_DATA)
			& (fifo_count != 2'h0);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= access;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (access & ~wb_we_i)
		begin
			case (wb_adr_i)
			`OFS_BAUD_CONTROL:
				wb_dat_o <= {25'h000_0000, state == st_idle, 1'b0,
					clock_polarity_select, wide_divisor_select, 3'h0};
			`OFS_RX_STAT_CTRL:
				wb_dat_o <= {24'h00_0000, serial_port_enable,
					nine_bit_receive, single_receive_enable,
					continuous_receive_enable, 2'h0,
					overrun_error_flag, fifo[rd_ptr][8]};
			`OFS_BAUD_DIV_LOW:
				wb_dat_o <= {24'h00_0000, baud_divisor_low};
			`OFS_BAUD_DIV_HIGH:
				wb_dat_o <= {24'h00_0000, baud_divisor_high};
			`OFS_TX_STAT_CTRL:
				wb_dat_o <= {24'h00_0000, master_clock_source,
					nine_bit_transmit, transmit_enable_bit, sync_mode,
					1'b0, high_rate_select, ~tsr_busy,
					transmit_ninth_bit};
			`OFS_RX_DATA:
				wb_dat_o <= {24'h00_0000, fifo[rd_ptr][7:0]};
			default:
				wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clock_polarity_select <= 1'b0;
			wide_divisor_select   <= 1'b0;
			baud_divisor_low      <= `REG_RESET;
			baud_divisor_high     <= `REG_RESET;
		end
		else if (wr_en)
		begin
			case (wb_adr_i)
			`OFS_BAUD_CONTROL:
			begin
				clock_polarity_select <= wb_dat_i[`BAUD_CLK_POLARITY];
				wide_divisor_select   <= wb_dat_i[`BAUD_WIDE_DIVISOR];
			end
			`OFS_BAUD_DIV_LOW:  baud_divisor_low  <= wb_dat_i[7:0];
			`OFS_BAUD_DIV_HIGH: baud_divisor_high <= wb_dat_i[7:0];
			default:            ;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			master_clock_source <= 1'b0;
			nine_bit_transmit   <= 1'b0;
			transmit_enable_bit <= 1'b0;
			sync_mode           <= 1'b0;
			high_rate_select    <= 1'b0;
			transmit_ninth_bit  <= 1'b0;
		end
		else if (wr_en & (wb_adr_i == `OFS_TX_STAT_CTRL))
		begin
			master_clock_source <= wb_dat_i[`TX_MASTER_CLOCK];
			nine_bit_transmit   <= wb_dat_i[`TX_NINE_BIT];
			transmit_enable_bit <= wb_dat_i[`TX_ENABLE];
			sync_mode           <= wb_dat_i[`TX_SYNC_MODE];
			high_rate_select    <= wb_dat_i[`TX_HIGH_RATE];
			transmit_ninth_bit  <= wb_dat_i[`TX_NINTH_BIT];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			serial_port_enable        <= 1'b0;
			nine_bit_receive          <= 1'b0;
			single_receive_enable     <= 1'b0;
			continuous_receive_enable <= 1'b0;
		end
		else if (wr_en & (wb_adr_i == `OFS_RX_STAT_CTRL))
		begin
			serial_port_enable        <= wb_dat_i[`RX_PORT_ENABLE];
			nine_bit_receive          <= wb_dat_i[`RX_NINE_BIT];
			single_receive_enable     <= wb_dat_i[`RX_SINGLE];
			continuous_receive_enable <= wb_dat_i[`RX_CONTINUOUS];
		end
		else if (rx_done)
			single_receive_enable <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_s1   <= 1'b0;
			data_s    <= 1'b0;
			strobe_s1 <= 1'b0;
			strobe_s  <= 1'b0;
			strobe_d  <= 1'b0;
		end
		else
		begin
			data_s1   <= data_i;
			data_s    <= data_s1;
			strobe_s1 <= strobe_i;
			strobe_s  <= strobe_s1;
			strobe_d  <= strobe_s;
		end
	end

	// ----------------------------------------------------------------
	// Shift events
	// ----------------------------------------------------------------
	always_comb
	begin
		port_on   = serial_port_enable & sync_mode;
		receiving = single_receive_enable | continuous_receive_enable;
		// Receive takes precedence; transmit needs both enables clear
		tx_run    = port_on & ~receiving & transmit_enable_bit & tsr_busy;
		rx_run    = port_on & receiving & ~overrun_error_flag;
		go        = tx_run | rx_run;
		divisor   = wide_divisor_select
			? {baud_divisor_high, baud_divisor_low}
			: {8'h00, baud_divisor_low};
		half_tick = (half_cnt == 16'h0000);
		if (master_clock_source)
		begin
			lead_ev  = go & ((state == st_idle)
				| ((state == st_trail) & half_tick));
			trail_ev = go & (state == st_lead) & half_tick;
		end
		else
		begin
			// Slave edges judged against the idle level
			lead_ev  = go & (strobe_s != strobe_d)
				& (strobe_s != clock_polarity_select);
			trail_ev = go & (strobe_s != strobe_d)
				& (strobe_s == clock_polarity_select);
		end
		char_bits = (rx_run ? nine_bit_receive : nine_bit_transmit)
			? `BITS_LONG : `BITS_SHORT;
		last_bit  = (bit_cnt == char_bits - 4'h1);
		next_rsr  = {data_s, receive_shift_register[8:1]};
		rx_char   = nine_bit_receive ? next_rsr
			: {1'b0, next_rsr[8:1]};
		rx_done   = trail_ev & rx_run & last_bit;
	end

	// ----------------------------------------------------------------
	// Clock generator and bit counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i | ~port_on | ~go)
		begin
			state    <= st_idle;
			half_cnt <= 16'h0000;
			bit_cnt  <= 4'h0;
			strobe_o <= (rst_i ? 1'b0 : clock_polarity_select);
		end
		else
		begin
			if (lead_ev | trail_ev)
				half_cnt <= divisor;
			else if (~half_tick)
				half_cnt <= half_cnt - 16'h0001;
			if (lead_ev)
			begin
				state    <= st_lead;
				strobe_o <= ~clock_polarity_select;
			end
			else if (trail_ev)
			begin
				state    <= st_trail;
				strobe_o <= clock_polarity_select;
				bit_cnt  <= last_bit ? 4'h0 : bit_cnt + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i | ~port_on)
		begin
			transmit_data_register  <= `REG_RESET;
			tdr_full                <= 1'b0;
			transmit_shift_register <= 9'h000;
			tsr_busy                <= 1'b0;
			data_o                  <= 1'b0;
		end
		else
		begin
			if (wr_en & (wb_adr_i == `OFS_TX_DATA))
			begin
				transmit_data_register <= wb_dat_i[7:0];
				tdr_full               <= 1'b1;
			end
			else if (~tsr_busy & tdr_full & transmit_enable_bit
				& ~receiving)
				tdr_full <= 1'b0;
			if (~tsr_busy & tdr_full & transmit_enable_bit & ~receiving)
			begin
				transmit_shift_register <= {transmit_ninth_bit,
					transmit_data_register};
				tsr_busy                <= 1'b1;
			end
			else if (tsr_busy & (receiving | ~transmit_enable_bit))
				tsr_busy <= 1'b0;
			else if (trail_ev & tx_run & last_bit)
				tsr_busy <= 1'b0;
			if (lead_ev & tx_run)
			begin
				data_o                  <= transmit_shift_register[0];
				transmit_shift_register <= transmit_shift_register >> 1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive path and FIFO
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i | ~rx_run)
			receive_shift_register <= 9'h000;
		else if (trail_ev)
			receive_shift_register <= next_rsr;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i | ~port_on)
		begin
			fifo[0]    <= 9'h000;
			fifo[1]    <= 9'h000;
			rd_ptr     <= 1'b0;
			fifo_count <= 2'h0;
		end
		else
		begin
			if (rx_done & (fifo_count != `FIFO_DEPTH))
				fifo[rd_ptr ^ fifo_count[0]] <= rx_char;
			if (pop)
				rd_ptr <= ~rd_ptr;
			case ({rx_done & (fifo_count != `FIFO_DEPTH), pop})
			2'b10:   fifo_count <= fifo_count + 2'h1;
			2'b01:   fifo_count <= fifo_count - 2'h1;
			default: fifo_count <= fifo_count;
			endcase
		end
	end

	// Set wins over any clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i | ~port_on)
		begin
			overrun_error_flag <= 1'b0;
			overrun_single     <= 1'b0;
		end
		else if (rx_done & (fifo_count == `FIFO_DEPTH))
		begin
			overrun_error_flag <= 1'b1;
			overrun_single     <= ~continuous_receive_enable;
		end
		else if (overrun_single & pop)
			overrun_error_flag <= 1'b0;
		else if (~overrun_single & ~continuous_receive_enable)
			overrun_error_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Pin enables and flag output
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_oe_n_o    <= 1'b1;
			strobe_oe_n_o  <= 1'b1;
			receive_flag_o <= 1'b0;
		end
		else
		begin
			// Data line released whenever any receive enable is set
			data_oe_n_o    <= ~(port_on & ~receiving
				& transmit_enable_bit);
			strobe_oe_n_o  <= ~(port_on & master_clock_source);
			receive_flag_o <= (next_count_nonzero());
		end
	end

	function automatic logic next_count_nonzero();
		logic push;
		push = rx_done & (fifo_count != `FIFO_DEPTH);
		next_count_nonzero = port_on & (push | (fifo_count > 2'h1)
			| ((fifo_count == 2'h1) & ~pop));
	endfunction : next_count_nonzero

endmodule : sync_serial_port

// ==== sync_serial_port_props.sv ====
// Port checker for the synchronous serial port
`timescale 1ns/10ps

module sync_serial_port_props
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        data_o,
	input wire logic        data_oe_n_o,
	input wire logic        strobe_i,
	input wire logic        strobe_o,
	input wire logic        strobe_oe_n_o,
	input wire logic        receive_flag_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic [3:0] quiet;

	// ----------------------------------------
	// Cycles since a clock line last moved
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			quiet <= 4'hF;
		else if ($changed(strobe_o) || $changed(strobe_i))
			quiet <= 4'h0;
		else if (quiet != 4'hF)
			quiet <= quiet + 4'h1;
	end

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_release;
		wb_ack_o || $past(wb_ack_o);
	endsequence

	a_ack_one_cycle: assert property (s_req |=> wb_ack_o)
		else $error("ack late");
	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_ack_needs_req: assert property ($rose(wb_ack_o)
		|-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	a_upper_read_zero: assert property (wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_reset_idle: assert property ($fell(rst_i) |-> data_oe_n_o
		&& strobe_oe_n_o && !receive_flag_o && !wb_ack_o)
		else $error("outputs not idle after reset");
	a_flag_drop_read: assert property ($fell(receive_flag_o)
		|-> s_release)
		else $error("receive flag fell without access");
	a_flag_after_edge: assert property ($rose(receive_flag_o)
		|-> quiet < 4'hA)
		else $error("receive flag rose away from clock edge");
	a_data_on_lead: assert property (!strobe_oe_n_o && !data_oe_n_o
		&& $changed(data_o) |-> $changed(strobe_o))
		else $error("data moved off the leading edge");
endmodule : sync_serial_port_props

bind sync_serial_port sync_serial_port_props sync_serial_port_props_i
(
	.clk_i,
	.rst_i,
	.wb_cyc_i,
	.wb_stb_i,
	.wb_we_i,
	.wb_dat_o,
	.wb_ack_o,
	.data_o,
	.data_oe_n_o,
	.strobe_i,
	.strobe_o,
	.strobe_oe_n_o,
	.receive_flag_o
);

// ==== far_end_device.sv ====
// Behavioural far-end device on the serial data and clock lines
`timescale 1ns/10ps

module far_end_device
(
	input  wire logic       line_clk_i,
	input  wire logic       pol_i,
	input  wire logic       talk_i,
	input  wire logic       clr_i,
	input  wire logic       data_i,
	input  wire logic [3:0] width_i,
	input  wire logic [8:0] base_i,
	output logic            data_o,
	output logic [8:0]      seen_o,
	output logic [7:0]      bits_o
);
	logic [3:0] idx;
	logic [8:0] chars;
	logic [8:0] word;

	// Each character is one above the last, so overwrites show
	assign word = base_i + chars;

	always @(posedge clr_i)
	begin
		idx = 4'h0;
		chars = 9'h000;
		bits_o = 8'h00;
		seen_o = 9'h000;
		data_o = 1'b0;
	end

	// Released line shows the opposite of its last level
	always @(negedge talk_i)
		data_o = ~data_o;

	always @(line_clk_i)
	begin
		if (line_clk_i !== pol_i)
		begin
			if (talk_i)
			begin
				data_o = word[idx];
				if (idx == width_i - 4'h1)
				begin
					idx = 4'h0;
					chars = chars + 9'h001;
				end
				else
					idx = idx + 4'h1;
			end
		end
		else
		begin
			seen_o = {data_i, seen_o[8:1]};
			bits_o = bits_o + 8'h01;
		end
	end
endmodule : far_end_device

// ==== testbench.sv ====
// Self-checking bench for the synchronous serial port
`timescale 1ns/10ps
`include "sync_serial_regs.svh"

module testbench;
	localparam logic [31:0] one = 32'h0000_0001;
	localparam logic [31:0] p_en = one << `RX_PORT_ENABLE;
	localparam logic [31:0] nine = one << `RX_NINE_BIT;
	localparam logic [31:0] sgl = one << `RX_SINGLE;
	localparam logic [31:0] cnt = one << `RX_CONTINUOUS;
	localparam logic [31:0] mst = one << `TX_MASTER_CLOCK;
	localparam logic [31:0] txe = one << `TX_ENABLE;
	localparam logic [31:0] syn = one << `TX_SYNC_MODE;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic        ext_clk = 1'b0;
	logic        pol = 1'b0;
	logic        talk = 1'b0;
	logic        clr = 1'b0;
	logic [3:0]  width = 4'h8;
	logic [8:0]  base = 9'h000;
	logic [31:0] rdat;
	logic        ack;
	logic        d_out;
	logic        d_oe_n;
	logic        s_out;
	logic        s_oe_n;
	logic        flag;
	logic        far_d;
	logic [8:0]  seen;
	logic [7:0]  bits;
	logic        data_w;
	logic        strobe_w;
	logic        last_s = 1'b0;
	int          run = 0;
	int          half_len = 0;
	int          num_errors = 0;
	int          compares = 0;

	assign data_w = !d_oe_n ? d_out : far_d;
	assign strobe_w = !s_oe_n ? s_out : ext_clk;

	always #2.5 clk = ~clk;

	always @(posedge clk)
	begin
		last_s <= strobe_w;
		if (strobe_w !== last_s)
		begin
			half_len <= run;
			run <= 1;
		end
		else
			run <= run + 1;
	end

	sync_serial_port sync_serial_port_i
	(
		.clk_i          (clk),
		.rst_i          (rst),
		.wb_cyc_i       (cyc),
		.wb_stb_i       (stb),
		.wb_we_i        (we),
		.wb_adr_i       (adr),
		.wb_sel_i       (sel),
		.wb_dat_i       (dat),
		.wb_dat_o       (rdat),
		.wb_ack_o       (ack),
		.data_i         (data_w),
		.data_o         (d_out),
		.data_oe_n_o    (d_oe_n),
		.strobe_i       (strobe_w),
		.strobe_o       (s_out),
		.strobe_oe_n_o  (s_oe_n),
		.receive_flag_o (flag)
	);

	far_end_device far_end_device_i
	(
		.line_clk_i (strobe_w),
		.pol_i      (pol),
		.talk_i     (talk),
		.clr_i      (clr),
		.data_i     (data_w),
		.width_i    (width),
		.base_i     (base),
		.data_o     (far_d),
		.seen_o     (seen),
		.bits_o     (bits)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_up;
		num_errors++;
		$display("wrong value wait expected done seen timeout");
		print_verdict();
	endtask : give_up

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n == 50)
			give_up();
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hF, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0000_0000, 4'hF, q);
	endtask : rd

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask : ticks

	task automatic start_far(input logic [8:0] b, input logic [3:0] w);
		@(posedge clk);
		clr <= 1'b1;
		base <= b;
		width <= w;
		talk <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask : start_far

	task automatic wait_until(input int n, input logic on_flag);
		int k;
		k = 0;
		while ((on_flag ? flag !== 1'b1 : bits < n) && k < 5000)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 5000)
			give_up();
	endtask : wait_until

	task automatic stop_port;
		wr(`OFS_RX_STAT_CTRL, 32'h0000_0000);
		wr(`OFS_TX_STAT_CTRL, 32'h0000_0000);
		talk <= 1'b0;
	endtask : stop_port

	// External master clock, idle level first, one cycle per bit
	task automatic pulses(input int n);
		repeat (n)
		begin
			ticks(8);
			ext_clk <= ~pol;
			ticks(8);
			ext_clk <= pol;
		end
	endtask : pulses

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [31:0] q;
		for (int a = 0; a < 32; a += 4)
		begin
			rd(8'(a), q);
			// Idle and shift-empty status read set with nothing running
			check("reset read", q, (8'(a) == `OFS_BAUD_CONTROL)
				? (one << `BAUD_RX_IDLE) : (8'(a) == `OFS_TX_STAT_CTRL)
				? (one << `TX_SHIFT_EMPTY) : {24'h00_0000, `REG_RESET});
		end
		wb(1'b1, `OFS_BAUD_DIV_LOW, 32'h0000_0055, 4'h0, q);
		wr(8'h1C, 32'h0000_00FF);
		rd(`OFS_BAUD_DIV_LOW, q);
		check("sel gated write", q, 32'h0000_0000);
		rd(8'h1C, q);
		check("unmapped read", q, 32'h0000_0000);
		check("lines released", 32'({d_oe_n, s_oe_n}), 32'h0000_0003);
		$display("test registers done");
	endtask : t_regs

	task automatic t_master_tx;
		logic [31:0] q;
		wr(`OFS_BAUD_DIV_LOW, 32'h0000_0007);
		wr(`OFS_TX_STAT_CTRL, mst | syn | txe);
		wr(`OFS_RX_STAT_CTRL, p_en);
		start_far(9'h000, 4'h8);
		wr(`OFS_TX_DATA, 32'h0000_00A5);
		wr(`OFS_TX_DATA, 32'h0000_003C);
		wait_until(16, 1'b0);
		ticks(40);
		check("tx chars", 32'(seen), 32'h0000_0079);
		check("tx clocks", 32'(bits), 32'h0000_0010);
		check("half period", 32'(half_len), 32'h0000_0008);
		check("idle low", 32'(strobe_w), 32'h0000_0000);
		rd(`OFS_TX_STAT_CTRL, q);
		check("shift empty", 32'(q[`TX_SHIFT_EMPTY]), one);
		stop_port();
		$display("test master transmit done");
	endtask : t_master_tx

	task automatic t_master_rx;
		logic [31:0] q;
		pol <= 1'b1;
		ext_clk <= 1'b1;
		wr(`OFS_BAUD_CONTROL, one << `BAUD_CLK_POLARITY);
		wr(`OFS_BAUD_DIV_HIGH, 32'h0000_0001);
		wr(`OFS_TX_STAT_CTRL, mst | syn | txe);
		wr(`OFS_RX_STAT_CTRL, p_en | nine);
		start_far(9'h15A, 4'h9);
		wr(`OFS_RX_STAT_CTRL, p_en | nine | sgl);
		ticks(1);
		check("data released", 32'(d_oe_n), one);
		wait_until(0, 1'b1);
		ticks(60);
		check("one char clocks", 32'(bits), 32'h0000_0009);
		check("idle high", 32'(strobe_w), one);
		check("narrow divisor", 32'(half_len), 32'h0000_0008);
		rd(`OFS_RX_STAT_CTRL, q);
		check("single cleared", 32'(q[`RX_SINGLE]), 32'h0000_0000);
		check("ninth bit", 32'(q[`RX_NINTH_BIT]), one);
		rd(`OFS_RX_DATA, q);
		check("rx byte", q, 32'h0000_005A);
		ticks(2);
		check("flag after read", 32'(flag), 32'h0000_0000);
		stop_port();
		$display("test master receive done");
	endtask : t_master_rx

	task automatic t_overrun;
		logic [31:0] q;
		logic [7:0]  n;
		pol <= 1'b0;
		ext_clk <= 1'b0;
		wr(`OFS_BAUD_CONTROL, 32'h0000_0000);
		wr(`OFS_TX_STAT_CTRL, mst | syn);
		wr(`OFS_RX_STAT_CTRL, p_en);
		start_far(9'h010, 4'h8);
		wr(`OFS_RX_STAT_CTRL, p_en | sgl | cnt);
		wait_until(24, 1'b0);
		ticks(20);
		rd(`OFS_RX_STAT_CTRL, q);
		check("overrun set", 32'(q[`RX_OVERRUN]), one);
		check("single gone", 32'(q[`RX_SINGLE]), 32'h0000_0000);
		check("cont kept", 32'(q[`RX_CONTINUOUS]), one);
		check("flag held", 32'(flag), one);
		wr(`OFS_RX_STAT_CTRL, p_en);
		ticks(4);
		n = bits;
		ticks(40);
		check("clock stopped", 32'(bits), 32'(n));
		rd(`OFS_RX_STAT_CTRL, q);
		check("overrun cleared", 32'(q[`RX_OVERRUN]), 32'h0000_0000);
		wr(`OFS_BAUD_CONTROL, one << `BAUD_WIDE_DIVISOR);
		wr(`OFS_RX_STAT_CTRL, p_en | sgl);
		wait_until(32, 1'b0);
		ticks(20);
		check("wide half period", 32'(half_len), 32'h0000_0108);
		rd(`OFS_RX_STAT_CTRL, q);
		check("single overrun", 32'(q[`RX_OVERRUN]), one);
		rd(`OFS_RX_DATA, q);
		check("first kept", q, 32'h0000_0010);
		rd(`OFS_RX_STAT_CTRL, q);
		check("read clears", 32'(q[`RX_OVERRUN]), 32'h0000_0000);
		rd(`OFS_RX_DATA, q);
		check("second kept", q, 32'h0000_0011);
		ticks(2);
		check("fifo empty", 32'(flag), 32'h0000_0000);
		stop_port();
		$display("test overrun done");
	endtask : t_overrun

	task automatic t_slave_rx;
		logic [31:0] q;
		wr(`OFS_TX_STAT_CTRL, syn);
		wr(`OFS_RX_STAT_CTRL, p_en);
		start_far(9'h0C3, 4'h8);
		wr(`OFS_RX_STAT_CTRL, p_en | sgl);
		check("clock released", 32'(s_oe_n), one);
		pulses(8);
		wait_until(0, 1'b1);
		rd(`OFS_RX_DATA, q);
		check("slave byte", q, 32'h0000_00C3);
		stop_port();
		$display("test slave receive done");
	endtask : t_slave_rx

	task automatic t_slave_tx;
		wr(`OFS_TX_STAT_CTRL, syn | txe | (one << `TX_NINE_BIT)
			| (one << `TX_NINTH_BIT));
		wr(`OFS_RX_STAT_CTRL, p_en);
		start_far(9'h000, 4'h9);
		wr(`OFS_TX_DATA, 32'h0000_0096);
		pulses(9);
		ticks(8);
		check("slave tx char", 32'(seen), 32'h0000_0196);
		check("slave tx clocks", 32'(bits), 32'h0000_0009);
		stop_port();
		$display("test slave transmit done");
	endtask : t_slave_tx

	initial
	begin
		ticks(10);
		rst <= 1'b0;
		t_regs();
		t_master_tx();
		t_master_rx();
		t_overrun();
		t_slave_rx();
		t_slave_tx();
		print_verdict();
	end
endmodule : testbench
